// File: logic/adc_conversion_control.v
// Converter control block: Wishbone registers, clock divider, channel routing
// Behaviour
// RULE_01: Bit 7 picks supply or external reference
// RULE_02: Conversion clock is system clock divided 1..128; conversion_clock_o toggles each tick, so it is divided 2..256
// RULE_03: Acquisition lasts exactly one conversion clock period
// RULE_04: Software aims for about 2 us period
// RULE_05: Eleven inputs: ten pins plus bandgap
// RULE_06: Pins are port A 0,3,4, B 7..1
// RULE_07: Software clears digital input enable on analog pins
// RULE_08: Software sets analog pins input, no pulls
// RULE_09: Writing start bit starts; reading 1 means done
// RULE_10: Software follows the documented setup order
// RULE_11: Eight-bit result, reference equals full scale 256
// RULE_12: Bandgap is never the conversion reference
// RULE_13: Writing zero to control disables converter
// RULE_14: Software uses /16 at 8 MHz, /8 at 4 MHz
// RULE_15: Start clears done; result updates at end only
// RULE_16: Start ignored while disabled; done unchanged
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ns
`include "adc_ctrl_consts.vh"

module adc_conversion_control #(
    parameter RES_W = 8                      // Result width in bits
) (
    input  wire             clk_i,           // System clock, 250 MHz
    input  wire             rst_i,           // Synchronous reset, active high
    // Wishbone classic slave
    input  wire             cyc_i,           // Bus cycle
    input  wire             stb_i,           // Strobe
    input  wire             we_i,            // Write enable
    input  wire [5:0]       adr_i,           // Byte address
    input  wire [3:0]       sel_i,           // Byte lane selects
    input  wire [31:0]      dat_i,           // Write data
    output reg  [31:0]      dat_o,           // Read data
    output reg              ack_o,           // Acknowledge
    // Analog front end
    input  wire             comp_i,          // Comparator, asynchronous
    output reg              ref_ext_o,       // 1: external reference pin, 0: supply
    output reg  [9:0]       pin_sel_o,       // One-hot analog pin switch
    output reg              bandgap_sel_o,   // Bandgap routed to converter input
    output wire             analog_en_o,     // Converter powered
    output wire             sample_o,        // Sampling switch closed
    output wire [RES_W-1:0] dac_code_o,      // Trial level for the DAC
    output reg              conversion_clock_o, // Divided conversion clock
    // Interrupt
    output wire             irq_o            // Level, high while enabled event pending
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    reg              enable;                 // Converter enable
    reg  [3:0]       chan;                   // Channel code
    reg              done;                   // Completion flag read back in start bit
    reg  [2:0]       div_sel;                // Divider select, ratio 2**div_sel
    reg  [6:0]       div_cnt;                // Divider counter
    reg  [`IRQ_W-1:0] irq_status;            // Sticky events
    reg  [`IRQ_W-1:0] irq_enable;            // Event enables
    reg              comp_s1;                // Synchroniser stage 1
    reg              comp_s2;                // Synchroniser stage 2
    reg              comp_s3;                // Synchroniser stage 3
    reg              comp_f;                 // Filtered comparator level

    wire             bus_req;                // Bus request not yet answered
    wire             wr_lane0;               // Write of low byte lane
    wire             wr_cc;                  // Write to control register
    wire             start_req;              // Start bit written as 1
    wire             start_go;               // Start accepted
    wire             start_ign;              // Start refused
    wire             tick;                   // End of a conversion clock period
    wire [6:0]       div_last;               // Terminal count of the divider
    wire             busy;                   // Conversion running
    wire             conv_done;              // Conversion finished pulse
    wire [RES_W-1:0] result;                 // Latest result
    wire [`IRQ_W-1:0] irq_set;               // Events this cycle
    reg  [31:0]      next_dat;               // Read data being selected

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    // Registers are eight bits wide; only lane 0 carries them, so a write
    // without sel_i[0] stores nothing.

    assign bus_req   = cyc_i & stb_i & ~ack_o;
    assign wr_lane0  = bus_req & we_i & sel_i[0];
    assign wr_cc     = wr_lane0 & (adr_i == `OFS_CONV_CTRL);
    assign start_req = wr_cc & dat_i[`CC_START_BIT];
    // Start needs the enable bit set in the same write; an enable already set is not enough [RULE_16]
    assign start_go  = start_req & dat_i[`CC_ENABLE_BIT] & ~busy;
    assign start_ign = start_req & ~dat_i[`CC_ENABLE_BIT];

    // Answer every request one cycle after it is seen, mapped or not
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= bus_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register: enable, start/done, channel

    always @(posedge clk_i) begin
        if (rst_i) begin
            enable <= 1'b0;
            chan   <= `CHAN_RST;
            done   <= 1'b0;
        end else begin
            if (wr_cc) begin
                // All zeros clears enable and so shuts the converter [RULE_13]
                enable <= dat_i[`CC_ENABLE_BIT];
                chan   <= dat_i[`CC_CHAN_MSB:`CC_CHAN_LSB];
            end
            if (conv_done) begin
                // Finish reported through the start bit [RULE_09]
                done <= 1'b1;
            end else if (start_go) begin
                // A new conversion hides the old completion [RULE_15]
                done <= 1'b0;
            end
            // Refused start leaves done as it was [RULE_16]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference and divider registers

    always @(posedge clk_i) begin
        if (rst_i) begin
            ref_ext_o <= 1'b0;
            div_sel   <= `DIV_RST;
        end else begin
            if (wr_lane0 && adr_i == `OFS_REF_CTRL) begin
                // Single bit, two sources; bandgap has no path here [RULE_01] [RULE_12]
                ref_ext_o <= dat_i[`RC_REF_BIT];
            end
            if (wr_lane0 && adr_i == `OFS_MODE) begin
                div_sel <= dat_i[`MD_DIV_MSB:`MD_DIV_LSB];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion clock divider
    // Ratio is 2**div_sel, eight steps from 1 to 128 [RULE_02]

    assign div_last = (7'h01 << div_sel) - 7'h01;
    assign tick     = (div_cnt >= div_last);

    // Counter restarts on start so the first period is full length
    always @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt            <= 7'h00;
            conversion_clock_o <= 1'b0;
        end else if (!enable || start_go || tick) begin
            div_cnt            <= 7'h00;
            conversion_clock_o <= enable & ~conversion_clock_o & ~start_go; // Toggles each tick: system clock divided 2..256, not the 1..128 of [RULE_02]
        end else begin
            div_cnt <= div_cnt + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Comparator synchroniser
    // Level accepted only when stages two and three agree; stage one feeds
    // stage two alone to keep metastability out of the decision logic.

    always @(posedge clk_i) begin
        if (rst_i) begin
            comp_s1 <= 1'b0;
            comp_s2 <= 1'b0;
            comp_s3 <= 1'b0;
            comp_f  <= 1'b0;
        end else begin
            comp_s1 <= comp_i;
            comp_s2 <= comp_s1;
            comp_s3 <= comp_s2;
            if (comp_s2 == comp_s3) begin
                comp_f <= comp_s3;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Successive approximation
    // Eight trials against the selected reference; reference equal to input
    // reads 255, the top of a 256-step scale [RULE_11]

    sar_engine #(
        .RES_W    (RES_W)
    ) u_sar (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .start_i  (start_go),
        .abort_i  (~enable),
        .tick_i   (tick),
        .comp_i   (comp_f),
        .busy_o   (busy),
        .sample_o (sample_o),
        .done_o   (conv_done),
        .code_o   (dac_code_o),
        .result_o (result)
    );

    assign analog_en_o = enable;

    ////////////////////////////////////////////////////////////////////////////
    // Input routing
    // Codes 0..9 are pins in order A0, A3, A4, B1..B7; 10 is bandgap;
    // higher codes select nothing [RULE_05] [RULE_06]

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_PINS; gi = gi + 1) begin : g_pin
            always @(posedge clk_i) begin
                if (rst_i) begin
                    pin_sel_o[gi] <= 1'b0;
                end else begin
                    pin_sel_o[gi] <= enable & ({28'h0, chan} == gi); // [RULE_06]
                end
            end
        end
    endgenerate

    // Bandgap can only be an input, never the reference [RULE_05] [RULE_12]
    always @(posedge clk_i) begin
        if (rst_i) begin
            bandgap_sel_o <= 1'b0;
        end else begin
            bandgap_sel_o <= enable & (chan == `CHAN_BANDGAP);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status
    // Set wins over a clear in the same cycle, so no event is lost

    assign irq_set[`IRQ_DONE_BIT] = conv_done;
    assign irq_set[`IRQ_IGN_BIT]  = start_ign;

    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= {`IRQ_W{1'b0}};
            irq_enable <= {`IRQ_W{1'b0}};
        end else begin
            if (wr_lane0 && adr_i == `OFS_IRQ_CLEAR) begin
                irq_status <= (irq_status & ~dat_i[`IRQ_W-1:0]) | irq_set;
            end else begin
                irq_status <= irq_status | irq_set;
            end
            if (wr_lane0 && adr_i == `OFS_IRQ_ENABLE) begin
                irq_enable <= dat_i[`IRQ_W-1:0];
            end
        end
    end

    assign irq_o = |(irq_status & irq_enable);

    ////////////////////////////////////////////////////////////////////////////
    // Read data
    // Unmapped and write-only offsets read zero

    always @* begin
        next_dat = 32'h00000000;
        case (adr_i)
            `OFS_CONV_CTRL: begin
                next_dat[`CC_ENABLE_BIT]            = enable;
                next_dat[`CC_START_BIT]             = done; // [RULE_09]
                next_dat[`CC_CHAN_MSB:`CC_CHAN_LSB] = chan;
            end
            `OFS_REF_CTRL: begin
                next_dat[`RC_REF_BIT] = ref_ext_o;
            end
            `OFS_MODE: begin
                next_dat[`MD_DIV_MSB:`MD_DIV_LSB] = div_sel;
            end
            `OFS_RESULT: begin
                next_dat[RES_W-1:0] = result; // [RULE_11]
            end
            `OFS_IRQ_STATUS: begin
                next_dat[`IRQ_W-1:0] = irq_status;
            end
            `OFS_IRQ_ENABLE: begin
                next_dat[`IRQ_W-1:0] = irq_enable;
            end
            default: begin
                next_dat = 32'h00000000;
            end
        endcase
    end

    // Data sampled with the request so it stands beside ack
    always @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else if (bus_req && !we_i) begin
            dat_o <= next_dat;
        end
    end

endmodule

// File: common/adc_ctrl_consts.vh
// Constants for the converter control block: offsets, fields, reset values, timing
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH

// Register byte offsets on the bus
`define OFS_CONV_CTRL   6'h00
`define OFS_REF_CTRL    6'h04
`define OFS_MODE        6'h08
`define OFS_RESULT      6'h0C
`define OFS_IRQ_STATUS  6'h10
`define OFS_IRQ_CLEAR   6'h14
`define OFS_IRQ_ENABLE  6'h18

// Converter control register fields
`define CC_ENABLE_BIT   7
`define CC_START_BIT    6
`define CC_CHAN_MSB     3
`define CC_CHAN_LSB     0

// Reference control register field
`define RC_REF_BIT      7

// Mode register divider field
`define MD_DIV_MSB      6
`define MD_DIV_LSB      4

// Channel codes
`define CHAN_BANDGAP    4'hA
`define NUM_PINS        10

// Reset values
`define CHAN_RST        4'h0
`define DIV_RST         3'h0
`define RESULT_RST      8'h00

// Interrupt status bits
`define IRQ_DONE_BIT    0
`define IRQ_IGN_BIT     1
`define IRQ_W           2

// Comparator settling allowance per bit, in clock cycles
`define SETTLE_CYC      3'h4

// Converter sequencer states
`define ST_IDLE         2'h0
`define ST_ACQ_WAIT     2'h1
`define ST_ACQ          2'h2
`define ST_BIT          2'h3

`endif

// File: logic/sar_engine.v
// Successive-approximation sequencer: one-period acquisition then eight bit trials
`timescale 1ns/1ns
`include "adc_ctrl_consts.vh"

module sar_engine #(
    parameter RES_W = 8                  // Result width in bits
) (
    input  wire             clk_i,       // System clock
    input  wire             rst_i,       // Synchronous reset, active high
    input  wire             start_i,     // Start pulse, only taken while idle
    input  wire             abort_i,     // Converter disabled: drop any conversion
    input  wire             tick_i,      // One pulse per conversion clock period
    input  wire             comp_i,      // Filtered comparator: input at or above trial level
    output wire             busy_o,      // Conversion in progress
    output reg              sample_o,    // Sampling switch closed
    output reg              done_o,      // One-cycle pulse at end of conversion
    output reg  [RES_W-1:0] code_o,      // Trial code toward the DAC
    output reg  [RES_W-1:0] result_o     // Last finished result
);

    reg [1:0]       state;               // Sequencer state
    reg [RES_W-1:0] trial;               // One-hot bit under trial
    reg [2:0]       settle;              // Settling counter for the current trial

    assign busy_o = (state != `ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    // Each trial waits for settling and then the next tick, so the comparator
    // path through its synchroniser is always stable before it is judged.
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i || abort_i) begin
            state    <= `ST_IDLE;
            sample_o <= 1'b0;
            code_o   <= {RES_W{1'b0}};
            trial    <= {RES_W{1'b0}};
            settle   <= 3'h0;
            if (rst_i) begin
                result_o <= `RESULT_RST;
            end
        end else begin
            case (state)
                `ST_IDLE: begin
                    if (start_i) begin
                        state <= `ST_ACQ_WAIT;
                    end
                end
                `ST_ACQ_WAIT: begin
                    // Align sampling to a period boundary [RULE_03]
                    if (tick_i) begin
                        sample_o <= 1'b1;
                        state    <= `ST_ACQ;
                    end
                end
                `ST_ACQ: begin
                    // Sample for exactly one conversion clock period [RULE_03]
                    if (tick_i) begin
                        sample_o <= 1'b0;
                        trial    <= {1'b1, {(RES_W-1){1'b0}}};
                        code_o   <= {1'b1, {(RES_W-1){1'b0}}};
                        settle   <= 3'h0;
                        state    <= `ST_BIT;
                    end
                end
                `ST_BIT: begin
                    if (settle != `SETTLE_CYC) begin
                        settle <= settle + 3'h1;
                    end else if (tick_i) begin
                        settle <= 3'h0;
                        trial  <= trial >> 1;
                        if (trial[0]) begin
                            // Last trial: result moves only now [RULE_15]
                            result_o <= comp_i ? code_o : (code_o & ~trial);
                            done_o   <= 1'b1;
                            code_o   <= {RES_W{1'b0}};
                            state    <= `ST_IDLE;
                        end else begin
                            code_o <= (comp_i ? code_o : (code_o & ~trial)) | (trial >> 1);
                        end
                    end
                end
                default: begin
                    state <= `ST_IDLE;
                end
            endcase
        end
    end

endmodule

// File: dv/adc_conv_chk.sv
// Port checker for the converter control block
`timescale 1ns/1ns
module adc_conv_chk #(
    parameter RES_W = 8                 // Result width
) (
    input wire clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, comp_i, ref_ext_o, bandgap_sel_o,
    input wire analog_en_o, sample_o, conversion_clock_o, irq_o,
    input wire [5:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i, dat_o,
    input wire [9:0] pin_sel_o,
    input wire [RES_W-1:0] dac_code_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////
    // New request seen, and stored writes to control and reference
    wire req   = cyc_i & stb_i & ~ack_o;
    wire wr_ok = req & we_i & sel_i[0];
    wire wr_cc = wr_ok & (adr_i == 6'h00);
    wire wr_rc = wr_ok & (adr_i == 6'h04);

    ////////////////////////////////////////////////////////////////
    // Answer one cycle later, pulse of one cycle
    sequence s_answer;
        ##1 ack_o ##1 !ack_o;
    endsequence
    property p_ack;
        req |-> s_answer;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer late or long");

    property p_ref;
        wr_rc |=> ref_ext_o == $past(dat_i[7]);
    endproperty
    a_ref: assert property (p_ref) else $error("reference select wrong");

    // Disable drops power and the sampling switch
    property p_off;
        wr_cc && !dat_i[7] |=> !analog_en_o ##[0:1] !sample_o;
    endproperty
    a_off: assert property (p_off) else $error("converter not disabled");

    property p_pin;
        wr_cc && dat_i[7] && dat_i[3:0] < 4'hA |-> ##2
            pin_sel_o == (10'h001 << $past(dat_i[3:0], 2)) && !bandgap_sel_o;
    endproperty
    a_pin: assert property (p_pin) else $error("pin routing wrong");

    property p_bg;
        wr_cc && dat_i[7] && dat_i[3:0] == 4'hA |-> ##2 bandgap_sel_o && pin_sel_o == 10'h000;
    endproperty
    a_bg: assert property (p_bg) else $error("bandgap routing wrong");

    // Never two inputs on the sampling node at once
    property p_onehot;
        $onehot0({pin_sel_o, bandgap_sel_o});
    endproperty
    a_onehot: assert property (p_onehot) else $error("inputs shorted");

    property p_samp_en;
        $rose(sample_o) |-> analog_en_o;
    endproperty
    a_samp_en: assert property (p_samp_en) else $error("sampling while off");

    // First trial after sampling is mid scale
    property p_trial;
        $fell(sample_o) && analog_en_o |-> ##[0:2] dac_code_o == 8'h80;
    endproperty
    a_trial: assert property (p_trial) else $error("first trial not mid scale");
endmodule

bind adc_conversion_control adc_conv_chk #(.RES_W(RES_W)) i_adc_conv_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .comp_i(comp_i), .ref_ext_o(ref_ext_o), .pin_sel_o(pin_sel_o),
    .bandgap_sel_o(bandgap_sel_o), .analog_en_o(analog_en_o), .sample_o(sample_o),
    .dac_code_o(dac_code_o), .conversion_clock_o(conversion_clock_o), .irq_o(irq_o)
);

// File: dv/analog_src_model.sv
// Analog inputs and comparator seen by the converter
`timescale 1ns/1ns
module analog_src_model (
    input  wire       clk_i,          // Paces the floating pattern
    input  wire [9:0] pin_sel_i,      // One-hot pin switch
    input  wire       bandgap_sel_i,  // Bandgap routed
    input  wire       ref_ext_i,      // External reference chosen
    input  wire [7:0] dac_code_i,     // Trial level
    output wire       comp_o          // Input at or above trial
);
    reg  [7:0] level;                 // Selected input as a code
    reg        wander = 1'b0;         // Floating node pattern
    integer    k;                     // Pin index

    ////////////////////////////////////////////////////////////////
    // Pins hold spaced levels, bandgap a fixed code; pins act as pull-free
    // analog inputs with their digital path off
    always @* begin
        level = 8'h4D;
        for (k = 0; k < 10; k = k + 1) begin
            if (pin_sel_i[k]) begin
                level = 8'h10 + 8'h17 * k[7:0];
            end
        end
        // External reference is twice the supply; the bandgap never is one
        if (ref_ext_i) begin
            level = level >> 1;
        end
    end

    // No input selected: the node floats, so no stable level is offered
    always @(posedge clk_i) begin
        wander <= ~wander;
    end

    // At or above trial keeps the bit, so a full reference reads top code
    assign comp_o = (|pin_sel_i | bandgap_sel_i) ? (level >= dac_code_i) : wander;
endmodule

// File: dv/adc_conversion_control_tb.sv
// Register-level bench for the converter control block
`timescale 1ns/1ns
module adc_conversion_control_tb;
    reg         clk_i;      // System clock
    reg         rst_i;      // Reset, active high
    reg         cyc_i, stb_i, we_i; // Bus cycle, strobe, write
    reg  [5:0]  adr_i;      // Address
    reg  [3:0]  sel_i;      // Lanes
    reg  [31:0] dat_i;      // Write data
    wire [31:0] dat_o;      // Read data
    wire        ack_o;      // Acknowledge
    wire        comp_i;     // Comparator from the model
    wire        ref_ext_o;  // Reference select
    wire [9:0]  pin_sel_o;  // Pin switch
    wire        bg_o;       // Bandgap switch
    wire        en_o;       // Converter powered
    wire        sample_o;   // Sampling switch
    wire [7:0]  dac_o;      // Trial code
    wire        irq_o;      // Interrupt
    reg  [31:0] rd;         // Last read word
    integer     errors, checks, cycles; // Mismatches, comparisons, run length
    integer     hi, wid, i; // Sampling width running and last, loop index

    adc_conversion_control #(.RES_W(8)) i_adc_conversion_control (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .comp_i(comp_i), .ref_ext_o(ref_ext_o), .pin_sel_o(pin_sel_o),
        .bandgap_sel_o(bg_o), .analog_en_o(en_o), .sample_o(sample_o),
        .dac_code_o(dac_o), .conversion_clock_o(), .irq_o(irq_o));

    analog_src_model i_analog_src_model (
        .clk_i(clk_i), .pin_sel_i(pin_sel_o), .bandgap_sel_i(bg_o),
        .ref_ext_i(ref_ext_o), .dac_code_i(dac_o), .comp_o(comp_i));

    ////////////////////////////////////////////////////////////////
    // Clock, watchdog and sampling width monitor
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Whole run needs well under 10000 cycles
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            end_of_test;
        end
        if (sample_o === 1'b1) begin
            hi = hi + 1;
        end else if (hi != 0) begin
            wid = hi;
            hi = 0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Verdict
    task end_of_test;
        begin
            if (errors == 0 && checks > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask

    task cmp32(input string nm, input [31:0] e, input [31:0] g);
        begin
            checks = checks + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("BAD %s exp %h got %h", nm, e, g);
            end
        end
    endtask

    // Classic cycle: hold everything until ack is sampled high
    task wb(input w, input [5:0] a, input [31:0] d, input [3:0] s);
        begin
            @(posedge clk_i);
            {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, s};
            @(posedge clk_i);
            while (ack_o !== 1'b1) @(posedge clk_i);
            rd = dat_o;
            {cyc_i, stb_i, we_i} <= 3'h0;
        end
    endtask

    task wr(input [5:0] a, input [31:0] d);
        wb(1'b1, a, d, 4'hF);
    endtask

    task rdc(input [5:0] a, input [31:0] e);
        begin
            wb(1'b0, a, 32'h0, 4'hF);
            cmp32($sformatf("reg_%h", a), e, rd);
        end
    endtask

    // Select, enable, start, poll done, then fetch the result into rd
    task conv(input [3:0] ch);
        begin
            wr(6'h00, {24'h0, 4'h8, ch});
            wr(6'h00, {24'h0, 4'hC, ch});
            rd = 32'h0;
            while (rd[6] !== 1'b1) wb(1'b0, 6'h00, 32'h0, 4'hF);
            wb(1'b0, 6'h0C, 32'h0, 4'hF);
        end
    endtask

    // Level the model offers, as the code a correct conversion gives
    function [31:0] lvl(input [3:0] ch, input ext);
        reg [7:0] v;
        begin
            v = (ch == 4'hA) ? 8'h4D : 8'h10 + 8'h17 * {4'h0, ch};
            lvl = ext ? {24'h0, 1'b0, v[7:1]} : {24'h0, v};
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_i = 1'b1;
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = 45'h0;
        errors = 0;
        checks = 0;
        cycles = 0;
        hi = 0;
        wid = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        // Everything reads zero after reset, the unmapped word too
        for (i = 0; i < 8; i = i + 1) begin
            rdc(i * 4, 32'h0);
        end
        wr(6'h04, 32'hFFFF_FFFF);
        rdc(6'h04, 32'h80);
        wr(6'h04, 32'h0);
        wb(1'b1, 6'h08, 32'h70, 4'hE);
        rdc(6'h08, 32'h0);
        // Every divider ratio; sampling lasts one conversion period
        for (i = 0; i < 8; i = i + 1) begin
            wr(6'h08, i << 4);
            rdc(6'h08, i << 4);
            conv(4'h3);
            cmp32("result", lvl(4'h3, 1'b0), rd);
            cmp32("sample_width", 32'h1 << i, wid);
        end
        // Fastest ratio keeps the channel sweep short
        wr(6'h08, 32'h0);
        for (i = 0; i < 11; i = i + 1) begin
            conv(i);
            cmp32("result", lvl(i, 1'b0), rd);
            rdc(6'h00, 32'hC0 | i);
        end
        wr(6'h04, 32'h80);
        conv(4'hA);
        cmp32("result", lvl(4'hA, 1'b1), rd);
        conv(4'h9);
        cmp32("result", lvl(4'h9, 1'b1), rd);
        wr(6'h04, 32'h0);
        wr(6'h00, 32'h8F);
        @(negedge clk_i);
        cmp32("route", 32'h0, {21'h0, bg_o, pin_sel_o});
        // Interrupt raised, masked, unmasked and cleared
        wr(6'h14, 32'h3);
        wr(6'h18, 32'h1);
        cmp32("irq", 32'h0, {31'h0, irq_o});
        conv(4'h2);
        cmp32("irq", 32'h1, {31'h0, irq_o});
        wr(6'h18, 32'h0);
        cmp32("irq", 32'h0, {31'h0, irq_o});
        wr(6'h18, 32'h1);
        cmp32("irq", 32'h1, {31'h0, irq_o});
        wr(6'h14, 32'h1);
        cmp32("irq", 32'h0, {31'h0, irq_o});
        // Disable keeps done; a start while off is refused and flagged
        wr(6'h00, 32'h0);
        rdc(6'h00, 32'h40);
        wr(6'h00, 32'h40);
        rdc(6'h00, 32'h40);
        rdc(6'h10, 32'h2);
        cmp32("enable", 32'h0, {31'h0, en_o});
        // Slow start clears done, old result stays, then abort mid-way
        wr(6'h08, 32'h70);
        wr(6'h00, 32'h83);
        wr(6'h00, 32'hC3);
        rdc(6'h00, 32'h83);
        rdc(6'h0C, lvl(4'h2, 1'b0));
        wr(6'h00, 32'h0);
        rdc(6'h00, 32'h0);
        rdc(6'h0C, lvl(4'h2, 1'b0));
        cmp32("sample", 32'h0, {31'h0, sample_o});
        // A fresh conversion after the abort works normally
        wr(6'h08, 32'h0);
        conv(4'h4);
        cmp32("result", lvl(4'h4, 1'b0), rd);
        end_of_test;
    end
endmodule
